// [hw/qdsu_top.sv]
// Quad 16-bit converter digital front end: frame decode, registers, update and clear
`timescale 1ns/10ps
`include "qdsu_cfg.svh"

// What this block does
// - Frames are 24 bits, most significant bit first, shifted on the serial clock.
// - Power-up loads every data register with zero code and clamps outputs.
// - Coding select low means twos complement, high means offset binary.
// - A falling frame strobe starts each transfer; each transfer needs a new strobe.
// - Strobe rising edge moves the shifted word into the selected register.
// - Beyond 24 clocks older bits leave on serial output, launched on rising edges.
// - Serial output joins readback only while the readout disable bit is clear.
// - Read flag set selects a register for readback; data bits are ignored.
// - Next frame shifts the selected register contents out on serial output.
// - Fine gain readback occupies the six lowest data bits.
// - Load pin low during shifting updates the addressed output at strobe rise.
// - Load pin high during shifting; its later falling edge updates all outputs.
// - Clear pin falling edge forces all outputs to the clear code.
// - After clear, outputs hold the clear value until newly programmed.
// - Clear pin low at power-on updates every output with the clear value.
// - Software clear frame performs the same clear as the clear pin.
// - Top four code bits drive 15 thermometer switches; low 12 drive ladder.
// - Offset binary 0x8000 is zero volts; twos complement 0x0000 is zero volts.
// - Select codes: function 000, data 010, coarse 011, fine 100, offset 101.
// - Function frame with channel address 000 is a no-operation frame.
module qdsu_top
  import qdsu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link
  input wire logic serial_clock,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  // Control pins
  input wire logic load_outputs_n,
  input wire logic async_clear_n,
  input wire logic coding_select,
  // Function register bits
  output logic [`QDSU_FUNC_BITS-1:0] function_bits,
  // Converter core
  output logic [`QDSU_CHANNELS-1:0][`QDSU_CODE_BITS-1:0] dac_code,
  output logic [`QDSU_CHANNELS-1:0][`QDSU_THERM_BITS-1:0] thermometer_switch,
  output logic [`QDSU_CHANNELS-1:0][`QDSU_LADDER_BITS-1:0] ladder_switch,
  output logic output_clamp
);

  qdsu_top_t st_r;
  qdsu_top_t st_nxt;

  // Link side signals
  logic [`QDSU_FRAME_BITS-1:0] frame_word;
  logic frame_valid;
  logic frame_tog;

  // Register memory port
  logic mem_we;
  logic [3:0] mem_wa;
  logic [`QDSU_CODE_BITS-1:0] mem_wd;
  logic [3:0] mem_ra;
  logic [`QDSU_CODE_BITS-1:0] mem_rd;

  // Decode helpers
  logic fs_rise;
  logic ld_fall;
  logic clr_now;
  logic frame_ok;
  logic [2:0] rsel;
  logic [2:0] addr;
  logic [`QDSU_CODE_BITS-1:0] data;
  logic [1:0] kind;
  logic kind_ok;
  logic [`QDSU_CODE_BITS-1:0] rb_val;

  // Switch drive per channel
  logic [`QDSU_CODE_BITS-1:0] code_flip;
  logic [`QDSU_CHANNELS-1:0][`QDSU_THERM_BITS-1:0] therm_w;
  logic [`QDSU_CHANNELS-1:0][`QDSU_LADDER_BITS-1:0] ladder_w;

  qdsu_link u_link (
    .rst(rst),
    .serial_clock(serial_clock),
    .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out),
    .readback_word(st_r.rb_word),
    .frame_word(frame_word),
    .frame_valid(frame_valid),
    .frame_tog(frame_tog)
  );

  // Memory index is {kind, channel}: data, coarse gain, fine gain, offset
  qdsu_regmem #(
    .WIDTH(`QDSU_CODE_BITS),
    .DEPTH(16),
    .AW(4)
  ) u_mem (
    .clock(clock),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_data(mem_wd),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  // One offset-binary datapath for both codings
  assign code_flip = st_r.cod_sync[1] ? 16'h0000 : `QDSU_MSB_FLIP;

  // Decoded from the held code, so the switches trail the code by one cycle
  generate
    for (genvar ch = 0; ch < `QDSU_CHANNELS; ch++) begin : g_chan
      logic [`QDSU_CODE_BITS-1:0] core_ch;
      assign core_ch = st_r.dac[ch] ^ code_flip;
      for (genvar i = 0; i < `QDSU_THERM_BITS; i++) begin : g_therm
        assign therm_w[ch][i] = (core_ch[15:12] > 4'(i));
      end
      assign ladder_w[ch] = core_ch[`QDSU_LADDER_BITS-1:0];
    end
  endgenerate

  always_comb begin
    st_nxt = st_r;
    mem_we = 1'b0;
    mem_wa = 4'h0;
    mem_wd = '0;
    mem_ra = 4'h0;
    clr_now = 1'b0;
    rb_val = '0;

    // Pin synchronisers; only the second stage is looked at
    st_nxt.fs_sync = {st_r.fs_sync[0], frame_sync_n};
    st_nxt.ld_sync = {st_r.ld_sync[0], load_outputs_n};
    st_nxt.clr_sync = {st_r.clr_sync[0], async_clear_n};
    st_nxt.cod_sync = {st_r.cod_sync[0], coding_select};
    st_nxt.tog_sync = {st_r.tog_sync[0], frame_tog};
    st_nxt.fs_prev = st_r.fs_sync[1];
    st_nxt.ld_prev = st_r.ld_sync[1];
    st_nxt.clr_prev = st_r.clr_sync[1];

    fs_rise = st_r.fs_sync[1] & ~st_r.fs_prev;
    ld_fall = ~st_r.ld_sync[1] & st_r.ld_prev;
    // Previous level resets high, so a pin held low at power-on reads as an edge
    clr_now = ~st_r.clr_sync[1] & st_r.clr_prev;

    // A strobe pulse with no clocks must not replay the last frame
    frame_ok = frame_valid && (st_r.tog_sync[1] != st_r.seen_tog);

    rsel = frame_word[`QDSU_REG_HI:`QDSU_REG_LO];
    addr = frame_word[`QDSU_ADDR_HI:`QDSU_ADDR_LO];
    data = frame_word[`QDSU_CODE_BITS-1:0];
    kind_ok = 1'b1;
    case (rsel)
      `QDSU_SEL_DATA: kind = 2'h0;
      `QDSU_SEL_COARSE: kind = 2'h1;
      `QDSU_SEL_FINE: kind = 2'h2;
      `QDSU_SEL_OFFSET: kind = 2'h3;
      default: begin
        kind = 2'h0;
        kind_ok = 1'b0;
      end
    endcase

    case (st_r.state)
      S_IDLE: begin
        if (fs_rise) begin
          st_nxt.seen_tog = st_r.tog_sync[1];
        end
        if (fs_rise && frame_ok) begin
          if (frame_word[`QDSU_RW_POS]) begin
            // Read request: remember the selection, data bits ignored
            st_nxt.rb_sel = {rsel, addr};
            if (rsel == `QDSU_SEL_FUNC) begin
              st_nxt.rb_word = {2'h0, rsel, addr, 10'h000, st_r.func};
            end else if (kind_ok && !addr[2]) begin
              st_nxt.op_kind = kind;
              st_nxt.idx = 3'h0;
              st_nxt.state = S_RB;
            end else begin
              st_nxt.rb_word = '0;
            end
          end else if (rsel == `QDSU_SEL_FUNC) begin
            case (addr)
              `QDSU_FN_CTRL: st_nxt.func = data[`QDSU_FUNC_BITS-1:0];
              `QDSU_FN_CLEAR: clr_now = 1'b1;
              `QDSU_FN_LOAD: begin
                st_nxt.idx = 3'h0;
                st_nxt.state = S_CP;
              end
              default: ;
            endcase
          end else if (kind_ok && (!addr[2] || addr == `QDSU_ADDR_ALL)) begin
            // Write into the selected register, one channel or all four
            st_nxt.op_kind = kind;
            st_nxt.op_data = data;
            st_nxt.op_all = (addr == `QDSU_ADDR_ALL);
            st_nxt.idx = (addr == `QDSU_ADDR_ALL) ? 3'h0 : {1'b0, addr[1:0]};
            // Load pin level seen during shifting picks the update mode
            st_nxt.op_load_outputs_n = !st_r.ld_sync[1] && (rsel == `QDSU_SEL_DATA);
            st_nxt.state = S_WR;
          end
        end else if (st_r.ld_pend) begin
          st_nxt.ld_pend = 1'b0;
          st_nxt.idx = 3'h0;
          st_nxt.state = S_CP;
        end
      end
      S_WR: begin
        mem_we = 1'b1;
        mem_wa = {st_r.op_kind, st_r.idx[1:0]};
        mem_wd = st_r.op_data;
        if (st_r.op_load_outputs_n) begin
          st_nxt.dac[st_r.idx[1:0]] = st_r.op_data;
          st_nxt.clamp = 1'b0;
        end
        if (st_r.op_all && st_r.idx != 3'h3) begin
          st_nxt.idx = st_r.idx + 3'h1;
        end else begin
          st_nxt.state = S_IDLE;
        end
      end
      S_CP: begin
        // One read in flight: issue channel idx, capture channel idx-1
        // Codes gather in a stage first so all outputs move on one edge
        mem_ra = {2'h0, st_r.idx[1:0]};
        if (st_r.idx != 3'h0) begin
          st_nxt.stage[st_r.idx[1:0] - 2'h1] = mem_rd;
        end
        if (st_r.idx == 3'h4) begin
          st_nxt.dac = st_r.stage;
          st_nxt.dac[`QDSU_CHANNELS-1] = mem_rd;
          st_nxt.clamp = 1'b0;
          st_nxt.state = S_IDLE;
        end else begin
          st_nxt.idx = st_r.idx + 3'h1;
        end
      end
      S_RB: begin
        mem_ra = {st_r.op_kind, st_r.rb_sel[1:0]};
        if (st_r.idx == 3'h0) begin
          st_nxt.idx = 3'h1;
        end else begin
          rb_val = (st_r.rb_sel[5:3] == `QDSU_SEL_FINE) ? (mem_rd & `QDSU_FINE_MASK) : mem_rd;
          st_nxt.rb_word = {2'h0, st_r.rb_sel, rb_val};
          st_nxt.state = S_IDLE;
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase

    // A load edge during a busy cycle waits; the set wins over the clear
    if (ld_fall) begin
      st_nxt.ld_pend = 1'b1;
    end

    // Clear beats this cycle's update and aborts a load copy; later all-channel write cycles still land; holds until reprogrammed
    if (clr_now) begin
      for (int ch = 0; ch < `QDSU_CHANNELS; ch++) begin
        st_nxt.dac[ch] = `QDSU_CLEAR_CODE;
      end
      st_nxt.clamp = 1'b0;
      if (st_r.state == S_CP) begin
        st_nxt.state = S_IDLE;
      end
    end

    // Switch drive registered from the per-channel decode
    st_nxt.therm = therm_w;
    st_nxt.ladder = ladder_w;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.fs_sync <= `QDSU_PIN_IDLE;
      st_r.ld_sync <= `QDSU_PIN_IDLE;
      st_r.clr_sync <= `QDSU_PIN_IDLE;
      st_r.cod_sync <= `QDSU_PIN_IDLE;
      st_r.fs_prev <= 1'b1;
      st_r.ld_prev <= 1'b1;
      st_r.clr_prev <= 1'b1;
      st_r.state <= S_IDLE;
      st_r.func <= `QDSU_FUNC_RESET;
      st_r.clamp <= 1'b1;
      for (int ch = 0; ch < `QDSU_CHANNELS; ch++) begin
        st_r.dac[ch] <= `QDSU_DATA_RESET;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  assign serial_data_out_en = ~st_r.func[`QDSU_RDOUT_DIS_POS];
  assign function_bits = st_r.func;
  assign dac_code = st_r.dac;
  assign thermometer_switch = st_r.therm;
  assign ladder_switch = st_r.ladder;
  assign output_clamp = st_r.clamp;

endmodule // qdsu_top

// [common/qdsu_cfg.svh]
// Constants of the quad converter serial front end
`ifndef QDSU_CFG_SVH
`define QDSU_CFG_SVH

// Frame layout
`define QDSU_FRAME_BITS 24
`define QDSU_CODE_BITS 16
`define QDSU_CHANNELS 4
`define QDSU_RW_POS 23
`define QDSU_REG_HI 21
`define QDSU_REG_LO 19
`define QDSU_ADDR_HI 18
`define QDSU_ADDR_LO 16
`define QDSU_LAST_BIT 5'h17

// Register select codes
`define QDSU_SEL_FUNC 3'h0
`define QDSU_SEL_DATA 3'h2
`define QDSU_SEL_COARSE 3'h3
`define QDSU_SEL_FINE 3'h4
`define QDSU_SEL_OFFSET 3'h5

// Function register channel address codes
`define QDSU_FN_NOP 3'h0
`define QDSU_FN_CTRL 3'h1
`define QDSU_FN_CLEAR 3'h4
`define QDSU_FN_LOAD 3'h5
`define QDSU_ADDR_ALL 3'h4

// Function register bits and register widths
`define QDSU_FUNC_BITS 6
`define QDSU_RDOUT_DIS_POS 0
`define QDSU_FINE_MASK 16'h003f

// Reset and special values
`define QDSU_DATA_RESET 16'h0000
`define QDSU_CLEAR_CODE 16'h0000
`define QDSU_FUNC_RESET 6'h00
`define QDSU_MSB_FLIP 16'h8000
`define QDSU_PIN_IDLE 2'h3

// Converter core split
`define QDSU_THERM_BITS 15
`define QDSU_LADDER_BITS 12

`endif

// [common/qdsu_pkg.sv]
// Types of the quad converter serial front end
`include "qdsu_cfg.svh"

package qdsu_pkg;

  typedef enum logic [1:0] {S_IDLE, S_WR, S_CP, S_RB} qdsu_state_t;

  typedef struct packed {
    logic [`QDSU_FRAME_BITS-1:0] shreg;
    logic [4:0] cnt;
    logic full;
    logic tog;
  } qdsu_link_t;

  typedef struct packed {
    logic [1:0] fs_sync;
    logic [1:0] ld_sync;
    logic [1:0] clr_sync;
    logic [1:0] cod_sync;
    logic [1:0] tog_sync;
    logic fs_prev;
    logic ld_prev;
    logic clr_prev;
    logic seen_tog;
    qdsu_state_t state;
    logic [2:0] idx;
    logic [1:0] op_kind;
    logic op_all;
    logic op_load_outputs_n;
    logic [`QDSU_CODE_BITS-1:0] op_data;
    logic ld_pend;
    logic [5:0] rb_sel;
    logic [`QDSU_FRAME_BITS-1:0] rb_word;
    logic [`QDSU_FUNC_BITS-1:0] func;
    logic clamp;
    logic [`QDSU_CHANNELS-1:0][`QDSU_CODE_BITS-1:0] stage;
    logic [`QDSU_CHANNELS-1:0][`QDSU_CODE_BITS-1:0] dac;
    logic [`QDSU_CHANNELS-1:0][`QDSU_THERM_BITS-1:0] therm;
    logic [`QDSU_CHANNELS-1:0][`QDSU_LADDER_BITS-1:0] ladder;
  } qdsu_top_t;

endpackage

// [hw/qdsu_regmem.sv]
// Small register memory with a registered read port
`timescale 1ns/10ps

module qdsu_regmem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } qdsu_mem_t;

  qdsu_mem_t st_r;
  qdsu_mem_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rd = st_r.mem[rd_addr];
    if (wr_en) begin
      st_nxt.mem[wr_addr] = wr_data;
    end
  end

  // Everything powers up at zero code
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rd;

endmodule // qdsu_regmem

// [hw/qdsu_link.sv]
// Serial clock domain: input shift register, edge count and serial output
`timescale 1ns/10ps
`include "qdsu_cfg.svh"

module qdsu_link
  import qdsu_pkg::*;
(
  // Reset
  input wire logic rst,
  // Serial pins
  input wire logic serial_clock,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  output logic serial_data_out,
  // Toward the system clock domain
  input wire logic [`QDSU_FRAME_BITS-1:0] readback_word,
  output logic [`QDSU_FRAME_BITS-1:0] frame_word,
  output logic frame_valid,
  output logic frame_tog
);

  qdsu_link_t st_r;
  qdsu_link_t st_nxt;
  logic open_r;
  logic sdo_r;

  always_comb begin
    st_nxt = st_r;
    if (!frame_sync_n) begin
      // First edge of a frame loads the readback word behind the new bit
      if (!open_r) begin
        st_nxt.shreg = {readback_word[`QDSU_FRAME_BITS-2:0], serial_data_in};
        st_nxt.cnt = 5'h01;
        st_nxt.full = 1'b0;
        st_nxt.tog = ~st_r.tog;
      end else begin
        st_nxt.shreg = {st_r.shreg[`QDSU_FRAME_BITS-2:0], serial_data_in};
        if (st_r.cnt == `QDSU_LAST_BIT) begin
          st_nxt.cnt = 5'h00;
          st_nxt.full = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 5'h01;
        end
      end
    end
  end

  // Device samples on the falling serial clock edge
  always_ff @(negedge serial_clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Cleared by the strobe itself, since the clock may stop between frames
  always_ff @(negedge serial_clock or posedge frame_sync_n or posedge rst) begin
    if (rst) begin
      open_r <= 1'b0;
    end else if (frame_sync_n) begin
      open_r <= 1'b0;
    end else begin
      open_r <= 1'b1;
    end
  end

  // Launched on the rising edge, valid at the next falling edge
  always_ff @(posedge serial_clock or posedge rst) begin
    if (rst) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= open_r ? st_r.shreg[`QDSU_FRAME_BITS-1] : readback_word[`QDSU_FRAME_BITS-1];
    end
  end

  assign serial_data_out = sdo_r;
  assign frame_word = st_r.shreg;
  // Whole multiples of the frame length only, so chains of devices also latch
  assign frame_valid = st_r.full && (st_r.cnt == 5'h00);
  assign frame_tog = st_r.tog;

endmodule // qdsu_link

// [test/qdsu_properties.sv]
// Concurrent checks on the quad converter front end ports
`timescale 1ns/10ps
`include "qdsu_cfg.svh"
module qdsu_properties (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link
  input wire logic serial_clock,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  // Control pins
  input wire logic load_outputs_n,
  input wire logic async_clear_n,
  input wire logic coding_select,
  // Outputs
  input wire logic [`QDSU_FUNC_BITS-1:0] function_bits,
  input wire logic [`QDSU_CHANNELS-1:0][`QDSU_CODE_BITS-1:0] dac_code,
  input wire logic [`QDSU_CHANNELS-1:0][`QDSU_THERM_BITS-1:0] thermometer_switch,
  input wire logic [`QDSU_CHANNELS-1:0][`QDSU_LADDER_BITS-1:0] ladder_switch,
  input wire logic output_clamp
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [4:0] quiet_r;
  logic [2:0] pins_r;
  // Cycles since a pin that may move the outputs last changed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_r <= 5'h00;
      pins_r <= 3'h7;
    end else begin
      pins_r <= {frame_sync_n, load_outputs_n, async_clear_n};
      if (pins_r != {frame_sync_n, load_outputs_n, async_clear_n}) quiet_r <= 5'h00;
      else if (quiet_r != 5'h1f) quiet_r <= quiet_r + 5'h01;
    end
  end
  // Expected switch drive; twos complement shares the offset path by a top bit flip
  function automatic bit sw_ok(input bit th, input logic [3:0][15:0] d, input logic c,
                               input logic [3:0][14:0] t, input logic [3:0][11:0] l);
    logic [15:0] core;
    sw_ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      core = c ? d[i] : d[i] ^ 16'h8000;
      for (int j = 0; j < 15; j++) if (th && t[i][j] != (core[15:12] > j)) sw_ok = 1'b0;
      if (!th && l[i] != core[11:0]) sw_ok = 1'b0;
    end
  endfunction
  sequence s_steady;
    ((dac_code == $past(dac_code)) && (coding_select == $past(coding_select)))[*6];
  endsequence
  property p_ladder;
    s_steady |-> sw_ok(1'b0, dac_code, coding_select, thermometer_switch, ladder_switch);
  endproperty
  a_ladder: assert property (p_ladder) else $error("ladder drive off code");
  property p_therm;
    s_steady |-> sw_ok(1'b1, dac_code, coding_select, thermometer_switch, ladder_switch);
  endproperty
  a_therm: assert property (p_therm) else $error("thermometer drive off code");
  property p_clear;
    $fell(async_clear_n) |-> ##[1:6] (dac_code == '0 && !output_clamp);
  endproperty
  a_clear: assert property (p_clear) else $error("clear pin did not clear");
  property p_quiet;
    quiet_r == 5'h1f |-> $stable(dac_code) && $stable(function_bits);
  endproperty
  a_quiet: assert property (p_quiet) else $error("outputs moved without cause");
  property p_rdout;
    (function_bits == $past(function_bits))[*2]
      |-> serial_data_out_en == !function_bits[`QDSU_RDOUT_DIS_POS];
  endproperty
  a_rdout: assert property (p_rdout) else $error("output enable wrong");
  property p_sdo_edge;
    serial_data_out != $past(serial_data_out) |-> serial_clock;
  endproperty
  a_sdo_edge: assert property (p_sdo_edge) else $error("serial out moved off rise");
  property p_clamp;
    output_clamp && quiet_r == 5'h1f |=> output_clamp;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp dropped alone");
  property p_load;
    $fell(load_outputs_n) |-> ##[1:20] !output_clamp;
  endproperty
  a_load: assert property (p_load) else $error("load pin did not update");
  c_clear: cover property ($fell(async_clear_n));
  c_load: cover property ($fell(load_outputs_n));
  c_rdout: cover property (!serial_data_out_en);
endmodule // qdsu_properties

// [test/qdsu_host_model.sv]
// Host serial port model driving frames into the converter front end
`timescale 1ns/10ps
module qdsu_host_model (
  // Serial pins
  output logic serial_clock,
  output logic frame_sync_n,
  output logic serial_data_in,
  input wire logic serial_data_out
);
  initial begin
    serial_clock = 1'b0;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end
  // Clock idles low so the first rise launches the top readback bit
  task automatic xfer(input logic [47:0] word, input int n, output logic [47:0] rx);
    rx = '0;
    #13 frame_sync_n = 1'b0;
    #62.5;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = word[i];
      serial_clock = 1'b1;
      #62.5;
      rx = {rx[46:0], serial_data_out};
      serial_clock = 1'b0;
      #62.5;
    end
    frame_sync_n = 1'b1;
    // Released line shows no stale bit
    serial_data_in = ~serial_data_in;
    #250;
  endtask
endmodule // qdsu_host_model

// [test/test_quad_dac_serial_update.sv]
// Self-checking bench of the quad converter serial front end
`timescale 1ns/10ps
`include "qdsu_cfg.svh"
module test_quad_dac_serial_update;
  logic clock, rst, load_outputs_n, async_clear_n, coding_select;
  logic serial_clock, frame_sync_n, serial_data_in, serial_data_out, serial_data_out_en;
  logic output_clamp;
  logic [`QDSU_FUNC_BITS-1:0] function_bits;
  logic [`QDSU_CHANNELS-1:0][`QDSU_CODE_BITS-1:0] dac_code;
  logic [`QDSU_CHANNELS-1:0][`QDSU_THERM_BITS-1:0] therm;
  logic [`QDSU_CHANNELS-1:0][`QDSU_LADDER_BITS-1:0] ladder;
  logic [47:0] rx;
  int errors, n_checks;
  qdsu_top dut_u (.clock(clock), .rst(rst), .serial_clock(serial_clock),
    .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
    .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
    .coding_select(coding_select), .function_bits(function_bits), .dac_code(dac_code),
    .thermometer_switch(therm), .ladder_switch(ladder), .output_clamp(output_clamp));
  qdsu_host_model host_u (.serial_clock(serial_clock), .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic finish_test;
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [47:0] word, input int n);
    host_u.xfer(word, n, rx);
  endtask
  // Bounded wait for one channel code, then compare
  task automatic wait_code(input int ch, input logic [15:0] exp);
    int k;
    for (k = 0; k < 40 && dac_code[ch] !== exp; k++) @(negedge clock);
    check(dac_code[ch], exp);
    if (k == 40) finish_test;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  initial begin
    // Raised after time zero so the idle serial clock domain sees the edge
    rst = 1'b0;
    load_outputs_n = 1'b1;
    async_clear_n = 1'b1;
    coding_select = 1'b0;
    @(negedge clock) rst = 1'b1;
    repeat (16) @(posedge clock);
    @(negedge clock) rst = 1'b0;
    idle(4);
    check(dac_code, '0);
    check({output_clamp, serial_data_out_en, function_bits}, 8'hc0);
    // Load high: writes wait for the load pin edge
    send(48'h12abcd, 24);
    send(48'h108000, 24);
    idle(20);
    check({output_clamp, dac_code}, {1'b1, 64'h0});
    load_outputs_n = 1'b0;
    wait_code(2, 16'habcd);
    check(dac_code[0], 16'h8000);
    // Load low: each 24-bit frame updates its channel at strobe rise
    send(48'h111234, 24);
    wait_code(1, 16'h1234);
    idle(8);
    check({therm[1], ladder[1]}, {15'h01ff, 12'h234});
    send(48'h11ffff, 23);
    send(48'h11ffff, 25);
    idle(20);
    check(dac_code[1], 16'h1234);
    send(48'h010001, 24);
    idle(20);
    check({serial_data_out_en, function_bits}, {1'b0, 6'h01});
    send(48'h010000, 24);
    idle(20);
    check({serial_data_out_en, function_bits}, {1'b1, 6'h00});
    // Readback of fine gain; data of the request frame is ignored
    send(48'h20ffff, 24);
    send(48'ha05555, 24);
    send(48'h000000, 24);
    check(rx[23:0], 24'h20003f);
    check(dac_code, 64'h0000_abcd_1234_8000);
    // Two frames through one device: the older one ripples out
    send({24'h13aaaa, 24'h110777}, 48);
    wait_code(1, 16'h0777);
    check(rx[23:0], 24'h13aaaa);
    check(dac_code[3], 16'h0000);
    idle(8);
    check(therm[1], 15'h00ff);
    coding_select = 1'b1;
    idle(10);
    check({therm[1], ladder[1]}, {15'h0000, 12'h777});
    coding_select = 1'b0;
    async_clear_n = 1'b0;
    idle(10);
    check(dac_code, '0);
    async_clear_n = 1'b1;
    idle(30);
    check(dac_code, '0);
    send(48'h13beef, 24);
    wait_code(3, 16'hbeef);
    send(48'h040000, 24);
    wait_code(3, 16'h0000);
    check(dac_code, '0);
    // Second reset with the clear pin held low and the load pin idle
    load_outputs_n = 1'b1;
    async_clear_n = 1'b0;
    rst = 1'b1;
    idle(4);
    check({output_clamp, serial_data_out_en, function_bits, dac_code}, {8'hc0, 64'h0});
    rst = 1'b0;
    idle(10);
    check({output_clamp, dac_code}, {1'b0, 64'h0});
    finish_test;
  end
endmodule // test_quad_dac_serial_update
bind qdsu_top qdsu_properties prop_u (.clock(clock), .rst(rst), .serial_clock(serial_clock),
  .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
  .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
  .load_outputs_n(load_outputs_n), .async_clear_n(async_clear_n),
  .coding_select(coding_select), .function_bits(function_bits), .dac_code(dac_code),
  .thermometer_switch(thermometer_switch), .ladder_switch(ladder_switch),
  .output_clamp(output_clamp));
